//--- rtl/clk_sel_params.svh
`ifndef CLK_SEL_PARAMS_SVH
`define CLK_SEL_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register bus geometry
// ----------------------------------------------------------------------------
`define REG_ADDR_W 4
`define REG_DATA_W 8

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define OFS_INTERNAL_OSC_CTRL 4'h0
`define OFS_MAIN_CLOCK_CTRL 4'h1
`define OFS_CPU_CLOCK_CTRL 4'h2
`define OFS_OSC_PIN_MODE_REG 4'h3

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define BIT_HS_OSC_STOP 0
`define BIT_HS_OSC_STABLE 1
`define BIT_MAIN_SRC_SELECT 0
`define BIT_PERIPH_SRC_SELECT 2
`define BIT_MAIN_SRC_ACTIVE 4
`define BIT_PERIPH_SRC_ACTIVE 5
`define BIT_CPU_DIV_LSB 0
`define BIT_CPU_DIV_MSB 2
`define BIT_CPU_SRC_SELECT 4

// ----------------------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------------------
`define RST_HS_OSC_STOP 1'h0
`define RST_SRC_SELECT 1'h0
`define RST_CPU_DIV 3'h1
`define RST_OSC_PIN_MODE 8'h00
`define CPU_DIV_MAX 3'h4
`define DIV_CNT_FULL 4'hF

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS 8
`define HS_STAB_TIME_NS 2000
`define HS_STAB_CYCLES ((`HS_STAB_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

//--- rtl/clk_sel_pkg.sv
package clk_sel_pkg;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef enum logic {
        SRC_INTERNAL,
        SRC_HS_SYSTEM
    } clk_src_t;

endpackage

//--- rtl/sync_agree.sv
`timescale 1ns/1ns

// ----------------------------------------------------------------------------
// Three-stage synchroniser; the output moves only once stages two and three agree
// ----------------------------------------------------------------------------
module sync_agree #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic clk_en,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] level_q
);

    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else if (clk_en) begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            level_q <= '0;
        end else if (clk_en) begin
            for (int i = 0; i < WIDTH; i++) begin
                if (s2_q[i] == s3_q[i]) begin
                    level_q[i] <= s3_q[i];
                end
            end
        end
    end

endmodule

//--- rtl/clk_select.sv
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/1ns
`include "clk_sel_params.svh"

// ----------------------------------------------------------------------------
// Operation
// ----------------------------------------------------------------------------
// Operation
// - After reset the internal high-speed oscillator runs on its own and feeds the CPU clock.
// - Writing zero to hs_osc_stop starts the internal high-speed oscillator.
// - hs_osc_stable_flag rises to one once the oscillator has run for its stabilisation time.
// - With periph_src_select at zero both main and peripheral clocks come from the internal oscillator.
// - With periph_src_select at one and main_src_select at zero the peripheral clock comes from hs_system_clk.
// - With cpu_src_select at zero the CPU runs from the main clock through the selected divider.
// - The divider codes 0 to 4 give division by 1, 2, 4, 8 and 16, reset to code 1 (division by 2), and other codes are refused.
// - osc_pin_mode_reg resets to zero so the oscillator pins stay plain inputs.

module clk_select #(
    parameter int STAB_CYCLES = `HS_STAB_CYCLES,
    parameter logic [2:0] DIV_RESET = `RST_CPU_DIV
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic clk_en,
    input wire clk_sel_pkg::reg_req_t reg_req,
    output logic [`REG_DATA_W-1:0] rdata_q,
    input wire logic int_osc_clk,
    input wire logic hs_system_clk,
    output logic hs_osc_run_q,
    output logic hs_osc_stable_flag_q,
    output logic main_clk_q,
    output logic periph_clk_q,
    output logic cpu_clk_q,
    output logic [`REG_DATA_W-1:0] osc_pin_mode_q
);

    // ------------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------------
    logic hs_osc_stop_q;
    logic main_src_select_q;
    logic periph_src_select_q;
    logic cpu_src_select_q;
    logic [2:0] cpu_div_q;
    logic [15:0] stab_cnt_q;

    logic wr_osc;
    logic wr_main;
    logic wr_cpu;
    logic wr_pin;

    assign wr_osc = reg_req.wr && (reg_req.addr == `OFS_INTERNAL_OSC_CTRL);
    assign wr_main = reg_req.wr && (reg_req.addr == `OFS_MAIN_CLOCK_CTRL);
    assign wr_cpu = reg_req.wr && (reg_req.addr == `OFS_CPU_CLOCK_CTRL);
    assign wr_pin = reg_req.wr && (reg_req.addr == `OFS_OSC_PIN_MODE_REG);

    // The oscillator is enabled by reset so the CPU has a clock at once.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hs_osc_stop_q <= `RST_HS_OSC_STOP;
            hs_osc_run_q <= ~`RST_HS_OSC_STOP;
        end else if (clk_en && wr_osc) begin
            hs_osc_stop_q <= reg_req.wdata[`BIT_HS_OSC_STOP];
            hs_osc_run_q <= ~reg_req.wdata[`BIT_HS_OSC_STOP];
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            main_src_select_q <= `RST_SRC_SELECT;
            periph_src_select_q <= `RST_SRC_SELECT;
        end else if (clk_en && wr_main) begin
            main_src_select_q <= reg_req.wdata[`BIT_MAIN_SRC_SELECT];
            periph_src_select_q <= reg_req.wdata[`BIT_PERIPH_SRC_SELECT];
        end
    end

    // A prohibited ratio code leaves the old ratio in place rather than
    // producing an undefined CPU clock.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cpu_src_select_q <= `RST_SRC_SELECT;
            cpu_div_q <= DIV_RESET;
        end else if (clk_en && wr_cpu) begin
            cpu_src_select_q <= reg_req.wdata[`BIT_CPU_SRC_SELECT];
            if (reg_req.wdata[`BIT_CPU_DIV_MSB:`BIT_CPU_DIV_LSB] <= `CPU_DIV_MAX) begin
                cpu_div_q <= reg_req.wdata[`BIT_CPU_DIV_MSB:`BIT_CPU_DIV_LSB];
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            osc_pin_mode_q <= `RST_OSC_PIN_MODE;
        end else if (clk_en && wr_pin) begin
            osc_pin_mode_q <= reg_req.wdata;
        end
    end

    // ------------------------------------------------------------------------
    // Oscillator stabilisation
    // ------------------------------------------------------------------------
    // Stopping the oscillator drops the flag at once; a restart counts again
    // from zero because accuracy is lost while it was halted.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stab_cnt_q <= '0;
            hs_osc_stable_flag_q <= 1'b0;
        end else if (clk_en) begin
            if (!hs_osc_run_q) begin
                stab_cnt_q <= '0;
                hs_osc_stable_flag_q <= 1'b0;
            end else if (stab_cnt_q >= 16'(STAB_CYCLES - 1)) begin
                hs_osc_stable_flag_q <= 1'b1;
            end else begin
                stab_cnt_q <= stab_cnt_q + 16'h0001;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Source sampling
    // ------------------------------------------------------------------------
    logic [1:0] src_lvl;
    logic int_lvl;
    logic hsys_lvl;
    logic int_gate_q;

    sync_agree #(
        .WIDTH(2)
    ) u_src_sync (
        .clk(clk),
        .rstn(rstn),
        .clk_en(clk_en),
        .async_in({hs_system_clk, int_osc_clk}),
        .level_q(src_lvl)
    );

    // The run bit is taken over only while the sampled oscillator is low, so
    // a stop or a restart never cuts a high phase short.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            int_gate_q <= ~`RST_HS_OSC_STOP;
        end else if (clk_en && !src_lvl[0]) begin
            int_gate_q <= hs_osc_run_q;
        end
    end

    assign int_lvl = src_lvl[0] & int_gate_q;
    assign hsys_lvl = src_lvl[1];

    // ------------------------------------------------------------------------
    // Glitch-free source switching
    // ------------------------------------------------------------------------
    clk_sel_pkg::clk_src_t main_req;
    clk_sel_pkg::clk_src_t periph_req;
    clk_sel_pkg::clk_src_t main_act_q;
    clk_sel_pkg::clk_src_t periph_act_q;

    always_comb begin
        main_req = clk_sel_pkg::SRC_INTERNAL;
        periph_req = clk_sel_pkg::SRC_INTERNAL;
        if (periph_src_select_q) begin
            periph_req = clk_sel_pkg::SRC_HS_SYSTEM;
            if (main_src_select_q) begin
                main_req = clk_sel_pkg::SRC_HS_SYSTEM;
            end
        end
    end

    function automatic logic src_level(input clk_sel_pkg::clk_src_t s, input logic a, input logic b);
        src_level = (s == clk_sel_pkg::SRC_HS_SYSTEM) ? b : a;
    endfunction

    logic main_swap;
    logic main_d;

    assign main_swap = (main_act_q != main_req) && !main_clk_q && !src_level(main_req, int_lvl, hsys_lvl);
    assign main_d = main_swap ? main_clk_q : src_level(main_act_q, int_lvl, hsys_lvl);

    // A switch happens only while the output and the new source are both low,
    // so no short high phase is produced, but the low phase around a switch can be cut short.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            main_act_q <= clk_sel_pkg::SRC_INTERNAL;
            main_clk_q <= 1'b0;
        end else if (clk_en) begin
            main_clk_q <= main_d;
            if (main_swap) begin
                main_act_q <= main_req;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            periph_act_q <= clk_sel_pkg::SRC_INTERNAL;
            periph_clk_q <= 1'b0;
        end else if (clk_en) begin
            if (periph_act_q != periph_req && !periph_clk_q && !src_level(periph_req, int_lvl, hsys_lvl)) begin
                periph_act_q <= periph_req;
            end else begin
                periph_clk_q <= src_level(periph_act_q, int_lvl, hsys_lvl);
            end
        end
    end

    // ------------------------------------------------------------------------
    // CPU clock divider
    // ------------------------------------------------------------------------
    logic main_rise;
    logic main_fall;
    logic [3:0] div_cnt_q;
    logic [3:0] div_cnt_next;
    logic [2:0] div_act_q;

    assign main_rise = main_d && !main_clk_q;
    assign main_fall = !main_d && main_clk_q;
    assign div_cnt_next = main_rise ? (div_cnt_q + 4'h1) : div_cnt_q;

    // Ratio changes are applied at the first falling main edge after the
    // counter wraps: every tap and the undivided clock are low there, so
    // the CPU sees neither a short high nor a short low phase.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            div_cnt_q <= '0;
            div_act_q <= DIV_RESET;
        end else if (clk_en) begin
            div_cnt_q <= div_cnt_next;
            if (main_fall && div_cnt_q == '0) begin
                div_act_q <= cpu_div_q;
            end
        end
    end

    // The CPU is always fed from the main clock; no subsystem clock exists
    // here, so cpu_src_select is stored and read back only.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cpu_clk_q <= 1'b0;
        end else if (clk_en) begin
            if (div_act_q == 3'h0) begin
                cpu_clk_q <= main_d;
            end else begin
                cpu_clk_q <= div_cnt_next[2'(div_act_q - 3'h1)];
            end
        end
    end

    // ------------------------------------------------------------------------
    // Register read-back
    // ------------------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata_q <= '0;
        end else if (clk_en) begin
            rdata_q <= '0;
            if (reg_req.rd) begin
                if (reg_req.addr == `OFS_INTERNAL_OSC_CTRL) begin
                    rdata_q[`BIT_HS_OSC_STOP] <= hs_osc_stop_q;
                    rdata_q[`BIT_HS_OSC_STABLE] <= hs_osc_stable_flag_q;
                end else if (reg_req.addr == `OFS_MAIN_CLOCK_CTRL) begin
                    rdata_q[`BIT_MAIN_SRC_SELECT] <= main_src_select_q;
                    rdata_q[`BIT_PERIPH_SRC_SELECT] <= periph_src_select_q;
                    rdata_q[`BIT_MAIN_SRC_ACTIVE] <= (main_act_q == clk_sel_pkg::SRC_HS_SYSTEM);
                    rdata_q[`BIT_PERIPH_SRC_ACTIVE] <= (periph_act_q == clk_sel_pkg::SRC_HS_SYSTEM);
                end else if (reg_req.addr == `OFS_CPU_CLOCK_CTRL) begin
                    rdata_q[`BIT_CPU_DIV_MSB:`BIT_CPU_DIV_LSB] <= cpu_div_q;
                    rdata_q[`BIT_CPU_SRC_SELECT] <= cpu_src_select_q;
                end else if (reg_req.addr == `OFS_OSC_PIN_MODE_REG) begin
                    rdata_q <= osc_pin_mode_q;
                end
            end
        end
    end

endmodule

//--- tb/clk_select_asserts.sv
`timescale 1ns/1ns
`include "clk_sel_params.svh"

module clk_select_asserts #(
    parameter int STAB_CYCLES = `HS_STAB_CYCLES
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic clk_en,
    input wire clk_sel_pkg::reg_req_t reg_req,
    input wire logic [`REG_DATA_W-1:0] rdata_q,
    input wire logic int_osc_clk,
    input wire logic hs_system_clk,
    input wire logic hs_osc_run_q,
    input wire logic hs_osc_stable_flag_q,
    input wire logic main_clk_q,
    input wire logic periph_clk_q,
    input wire logic cpu_clk_q,
    input wire logic [`REG_DATA_W-1:0] osc_pin_mode_q
);
    // ----
    // Helpers
    // ----
    // A switch may hold the clock low for a whole source period, so compare only once settled.
    logic per_sel_q;
    logic [5:0] settle_q;
    int run_cnt_q;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            per_sel_q <= 1'b0;
            settle_q <= 6'h00;
        end else if (clk_en && reg_req.wr && reg_req.addr == `OFS_MAIN_CLOCK_CTRL) begin
            per_sel_q <= reg_req.wdata[`BIT_PERIPH_SRC_SELECT];
            settle_q <= 6'h00;
        end else if (settle_q != 6'h3F) begin
            settle_q <= settle_q + 6'h01;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            run_cnt_q <= 0;
        end else if (!hs_osc_run_q) begin
            run_cnt_q <= 0;
        end else if (clk_en && run_cnt_q < STAB_CYCLES + 2) begin
            run_cnt_q <= run_cnt_q + 1;
        end
    end

    // ----
    // Properties
    // ----
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence s_write(logic [3:0] a);
        clk_en && reg_req.wr && reg_req.addr == a;
    endsequence

    sequence s_read(logic [3:0] a);
        clk_en && reg_req.rd && reg_req.addr == a;
    endsequence

    AST_RUN_AFTER_RESET: assert property ($rose(rstn) |-> hs_osc_run_q)
        else $error("oscillator not running after reset");
    AST_PIN_MODE_RESET: assert property ($rose(rstn) |-> osc_pin_mode_q == 8'h00)
        else $error("pin mode not cleared by reset");
    AST_STOP_CLEAR_STARTS: assert property (s_write(`OFS_INTERNAL_OSC_CTRL) ##0 !reg_req.wdata[0] |=> hs_osc_run_q)
        else $error("oscillator did not start");
    AST_STABLE_AFTER_TIME: assert property ($rose(hs_osc_stable_flag_q) |-> run_cnt_q == STAB_CYCLES)
        else $error("stable flag rose at wrong time");
    AST_STABLE_DROPS: assert property ($fell(hs_osc_run_q) |-> ##[0:1] !hs_osc_stable_flag_q)
        else $error("stable flag kept after stop");
    AST_READ_STATUS: assert property (s_read(`OFS_INTERNAL_OSC_CTRL) |=>
        rdata_q[1:0] == {$past(hs_osc_stable_flag_q), !$past(hs_osc_run_q)})
        else $error("status read mismatch");
    AST_PERIPH_FOLLOWS_MAIN: assert property (settle_q == 6'h3F && !per_sel_q |-> periph_clk_q == main_clk_q)
        else $error("peripheral clock not on internal source");
    AST_DIV_CODE_LEGAL: assert property (s_read(`OFS_CPU_CLOCK_CTRL) |=> rdata_q[2:0] <= `CPU_DIV_MAX)
        else $error("prohibited divider code held");
    AST_PIN_MODE_WRITE: assert property (s_write(`OFS_OSC_PIN_MODE_REG) |=> osc_pin_mode_q == $past(reg_req.wdata))
        else $error("pin mode write lost");
    AST_MAIN_NO_RUNT: assert property ($rose(main_clk_q) |-> main_clk_q [*3])
        else $error("short main clock pulse");
    AST_CPU_NO_RUNT: assert property ($fell(cpu_clk_q) |-> !cpu_clk_q [*3])
        else $error("short cpu clock gap");
endmodule

bind clk_select clk_select_asserts #(.STAB_CYCLES(STAB_CYCLES)) u_chk (.clk, .rstn, .clk_en, .reg_req, .rdata_q,
    .int_osc_clk, .hs_system_clk, .hs_osc_run_q, .hs_osc_stable_flag_q, .main_clk_q, .periph_clk_q, .cpu_clk_q,
    .osc_pin_mode_q);

//--- tb/tb_top.sv
`timescale 1ns/1ns
`include "clk_sel_params.svh"

module tb_top;
    localparam int STAB = 8;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic clk_en = 1'b1;
    logic int_osc_clk = 1'b0;
    logic hs_system_clk = 1'b0;
    clk_sel_pkg::reg_req_t reg_req = '0;
    logic [7:0] rdata_q, osc_pin_mode_q, w, got;
    logic hs_osc_run_q, hs_osc_stable_flag_q, main_clk_q, periph_clk_q, cpu_clk_q, per, msel;
    logic [2:0] code_q;
    int errors = 0;
    int num_checks = 0;
    int seed = 77925;
    int nm, np, nc, n;

    always #4 clk = ~clk;
    // Source periods are whole multiples of clk (10 and 7 cycles), so the sampling phase repeats each period.
    always #40 int_osc_clk = ~int_osc_clk;
    always #28 hs_system_clk = ~hs_system_clk;

    clk_select #(.STAB_CYCLES(STAB), .DIV_RESET(`RST_CPU_DIV)) dut (.clk, .rstn, .clk_en, .reg_req, .rdata_q,
        .int_osc_clk, .hs_system_clk, .hs_osc_run_q, .hs_osc_stable_flag_q, .main_clk_q, .periph_clk_q, .cpu_clk_q,
        .osc_pin_mode_q);

    // ----
    // Tasks and expectations
    // ----
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk_val(input logic [7:0] g, input logic [7:0] e);
        num_checks++;
        if (g !== e) begin
            errors++;
            $display("unexpected value at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    // Edge counts over a window may land one off, depending on phase.
    task automatic chk_count(input int g, input int e);
        num_checks++;
        if (g < e - 1 || g > e + 1) begin
            errors++;
            $display("unexpected count at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_req.addr <= a;
        reg_req.wdata <= d;
        reg_req.wr <= 1'b1;
        @(posedge clk);
        reg_req.wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_req.addr <= a;
        reg_req.rd <= 1'b1;
        @(posedge clk);
        reg_req.rd <= 1'b0;
        #1;
        d = rdata_q;
    endtask

    task automatic count_edges(input int cycles);
        logic pm, pp, pc;
        nm = 0;
        np = 0;
        nc = 0;
        {pm, pp, pc} = {main_clk_q, periph_clk_q, cpu_clk_q};
        repeat (cycles) begin
            @(posedge clk);
            #1;
            nm += int'(main_clk_q && !pm);
            np += int'(periph_clk_q && !pp);
            nc += int'(cpu_clk_q && !pc);
            {pm, pp, pc} = {main_clk_q, periph_clk_q, cpu_clk_q};
        end
    endtask

    // Rising edges in 140 cycles: 14 from the internal source, 20 from the system source.
    function automatic int src_edges(input logic hs);
        return hs ? 20 : 14;
    endfunction

    function automatic logic [7:0] exp_cpu(input logic [7:0] d, input logic [2:0] old);
        return {3'h0, d[4], 1'b0, (d[2:0] > `CPU_DIV_MAX) ? old : d[2:0]};
    endfunction

    // ----
    // Sequence
    // ----
    initial begin
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        rd(`OFS_OSC_PIN_MODE_REG, got);
        chk_val(got, `RST_OSC_PIN_MODE);
        rd(`OFS_CPU_CLOCK_CTRL, got);
        chk_val(got, {5'h00, `RST_CPU_DIV});
        rd(4'h7, got);
        chk_val(got, 8'h00);
        chk_val({7'h00, hs_osc_run_q}, 8'h01);
        repeat (60) @(posedge clk);
        count_edges(160);
        chk_count(nm, 16);
        chk_count(nc, 8);
        $display("test reset defaults done");
        wr(`OFS_INTERNAL_OSC_CTRL, 8'h01);
        repeat (3) @(posedge clk);
        #1;
        chk_val({6'h00, hs_osc_stable_flag_q, hs_osc_run_q}, 8'h00);
        wr(`OFS_INTERNAL_OSC_CTRL, 8'h00);
        #1;
        chk_val({6'h00, hs_osc_stable_flag_q, hs_osc_run_q}, 8'h01);
        n = 0;
        while (hs_osc_stable_flag_q !== 1'b1 && n < 1000) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk_val(8'(n), 8'(STAB));
        rd(`OFS_INTERNAL_OSC_CTRL, got);
        chk_val(got, 8'h02);
        $display("test oscillator restart done");
        for (int s = 3; s >= 0; s--) begin
            per = s[1];
            msel = s[0];
            wr(`OFS_MAIN_CLOCK_CTRL, {5'h00, per, 1'b0, msel});
            repeat (40) @(posedge clk);
            count_edges(140);
            chk_count(nm, src_edges(per & msel));
            chk_count(np, src_edges(per));
            rd(`OFS_MAIN_CLOCK_CTRL, got);
            chk_val(got, {2'b00, per, per & msel, 1'b0, per, 1'b0, msel});
        end
        $display("test source select done");
        for (int c = 0; c < 5; c++) begin
            w = (8'($random(seed)) & 8'h10) | 8'(c);
            wr(`OFS_CPU_CLOCK_CTRL, w);
            repeat (180) @(posedge clk);
            count_edges(160);
            chk_count(nc, 16 >> c);
        end
        code_q = 3'h4;
        for (int i = 0; i < 8; i++) begin
            w = (i == 0) ? 8'h15 : (i == 1) ? 8'h07 : 8'($random(seed)) & 8'h17;
            wr(`OFS_CPU_CLOCK_CTRL, w);
            rd(`OFS_CPU_CLOCK_CTRL, got);
            chk_val(got, exp_cpu(w, code_q));
            code_q = (w[2:0] > `CPU_DIV_MAX) ? code_q : w[2:0];
        end
        $display("test cpu divider done");
        for (int i = 0; i < 6; i++) begin
            w = 8'($random(seed));
            wr(`OFS_OSC_PIN_MODE_REG, w);
            rd(`OFS_OSC_PIN_MODE_REG, got);
            chk_val(got, w);
        end
        @(posedge clk);
        clk_en <= 1'b0;
        wr(`OFS_OSC_PIN_MODE_REG, ~w);
        @(posedge clk);
        clk_en <= 1'b1;
        rd(`OFS_OSC_PIN_MODE_REG, got);
        chk_val(got, w);
        chk_val(osc_pin_mode_q, w);
        $display("test pin mode done");
        end_of_test;
    end

    initial begin
        #200000;
        errors++;
        end_of_test;
    end
endmodule
